// [rtl/dac_ctl_defs.vh]
// constants for the stereo converter control port and housekeeping
`ifndef DAC_CTL_DEFS_VH
`define DAC_CTL_DEFS_VH

// ********************************
// register indices
// ********************************
`define DAC_REG_FORMAT      3'h0
`define DAC_REG_RATE        3'h1
`define DAC_REG_MIX         3'h2
`define DAC_REG_LEFT_ATT    3'h3
`define DAC_REG_RIGHT_ATT   3'h4
`define DAC_REG_DOUT        3'h5
`define DAC_REG_CS_LOW      3'h6
`define DAC_REG_CS_CAT      3'h7
`define DAC_REG_COUNT       8
`define DAC_ADDR_LIMIT      5'h08

// ********************************
// register reset values
// ********************************
`define DAC_DEF_FORMAT      8'h0b
`define DAC_DEF_RATE        8'h01
`define DAC_DEF_MIX         8'h94
`define DAC_DEF_LEFT_ATT    8'hff
`define DAC_DEF_RIGHT_ATT   8'hff
`define DAC_DEF_DOUT        8'h01
`define DAC_DEF_CS_LOW      8'h00
`define DAC_DEF_CS_CAT      8'h04

// ********************************
// field positions
// ********************************
`define DAC_TRST_BIT        0
`define DAC_SOFT_MUTE_BIT_BIT       0
`define DAC_DEEMPH_HI       3
`define DAC_DEEMPH_LO       2
`define DAC_SPEED_HI        5
`define DAC_SPEED_LO        4
`define DAC_SPEED_NORMAL    2'h0
`define DAC_DEEMPH_44K      2'h0
`define DAC_DEEMPH_OFF      2'h1
`define DAC_DEEMPH_48K      2'h2
`define DAC_DEEMPH_32K      2'h3

// ********************************
// timing counts (frame clock periods, system clocks or serial bits)
// ********************************
`define DAC_ZERO_FRAMES     14'd8192
`define DAC_RAMP_STEPS      11'd1024
`define DAC_RELEASE_FRAMES  3'd3
`define DAC_ZHOLD_FRAMES    3'd5
`define DAC_MCLK_LOSS       8'd64
`define DAC_SPI_BITS        5'd16

`endif

// [rtl/dac_control_port.v]
// control port, register bank, zero detect, soft mute and reset sequencing
`timescale 1ns/1ns
`include "dac_ctl_defs.vh"

// Operation
// - de-emphasis field picks 44.1k, off, 48k, 32k
// - non-normal speed mode forces de-emphasis off
// - zero flag high after 8192 zero frames
// - any nonzero sample drops zero flag immediately, outside timing-reset hold
// - timing reset raises flag, drops 4-5 frames later
// - soft mute ramps down over 1024 frames
// - unmute ramps up from reached level
// - power-down loads defaults, resets filter, powers off
// - power-down holds zero flag low
// - timing reset keeps registers, powers off converter
// - internal reset releases 2-3 frames after set
// - clocks may stop in power-down or reset
// - 3-wire frame: chip, rw=1, addr, data
// - write accepted only on chip address match
// - sample on clock rise, commit on select rise
// - two-wire frame: chip, rw=0, addr, data, acks
// - two-wire write starts on start, commits on stop
// - one register per transaction, no increment
// - writes ignored in power-down or without master clock
module dac_control_port #(
  parameter [13:0] ZERO_FRAMES  = `DAC_ZERO_FRAMES,
  parameter [10:0] RAMP_STEPS   = `DAC_RAMP_STEPS,
  parameter [7:0]  MCLK_TIMEOUT = `DAC_MCLK_LOSS
) (
  input  wire        clock,
  input  wire        arst_n,
  input  wire        powerDownN,
  input  wire        twoWireSel,
  input  wire        masterClockIn,
  input  wire        frameClock,
  input  wire        selectN,
  input  wire        ctlSerialClock,
  input  wire        ctlSerialIn,
  input  wire        sclIn,
  input  wire        sdaIn,
  input  wire        addrSelectPin0,
  input  wire        addrSelectPin1,
  input  wire        sampleValid,
  input  wire [23:0] sampleLeft,
  input  wire [23:0] sampleRight,
  output reg         sdaOut,
  output reg         sdaOeN,
  output reg         zeroFlagOut,
  output reg  [1:0]  deemphSelect,
  output reg  [10:0] muteGain,
  output reg         converterPowerDown,
  output reg         internalReset,
  output reg  [7:0]  regFormat,
  output reg  [7:0]  regRate,
  output reg  [7:0]  regMix,
  output reg  [7:0]  regLeftAtt,
  output reg  [7:0]  regRightAtt,
  output reg  [7:0]  regDigitalOut,
  output reg  [7:0]  regCsLow,
  output reg  [7:0]  regCsCategory
);

  // ********************************
  // helpers
  // ********************************
  function [7:0] defaultOf;
    input [2:0] idx;
    begin
      case (idx)
        `DAC_REG_FORMAT:    defaultOf = `DAC_DEF_FORMAT;
        `DAC_REG_RATE:      defaultOf = `DAC_DEF_RATE;
        `DAC_REG_MIX:       defaultOf = `DAC_DEF_MIX;
        `DAC_REG_LEFT_ATT:  defaultOf = `DAC_DEF_LEFT_ATT;
        `DAC_REG_RIGHT_ATT: defaultOf = `DAC_DEF_RIGHT_ATT;
        `DAC_REG_DOUT:      defaultOf = `DAC_DEF_DOUT;
        `DAC_REG_CS_LOW:    defaultOf = `DAC_DEF_CS_LOW;
        default:            defaultOf = `DAC_DEF_CS_CAT;
      endcase
    end
  endfunction

  // header byte: chip[7:6], rw[5], register[4:0]
  function headerOk;
    input [7:0] hdr;
    input       rwWant;
    input [1:0] chip;
    begin
      headerOk = (hdr[7:6] == chip) && (hdr[5] == rwWant)
                 && (hdr[4:0] < `DAC_ADDR_LIMIT);
    end
  endfunction

  // ********************************
  // pin synchronisers
  // ********************************
  reg  [9:0] syncA;
  reg  [9:0] syncB;
  reg  [9:0] syncC;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 10'h3ff;
      syncB <= 10'h3ff;
      syncC <= 10'h3ff;
    end else begin
      syncA <= {powerDownN, masterClockIn, frameClock, selectN, ctlSerialClock,
                ctlSerialIn, sclIn, sdaIn, addrSelectPin1, addrSelectPin0};
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  wire       pdnOk     = syncB[9];
  wire       fsTick    = syncB[7] & ~syncC[7];
  wire       mclkEdge  = syncB[8] ^ syncC[8];
  wire       csnRise   = syncB[6] & ~syncC[6];
  wire       cclkRise  = syncB[5] & ~syncC[5];
  wire       sclRise   = syncB[3] & ~syncC[3];
  wire       sclFall   = ~syncB[3] & syncC[3];
  wire       i2cStart  = syncB[3] & syncC[3] & ~syncB[2] & syncC[2];
  wire       i2cStop   = syncB[3] & syncC[3] & syncB[2] & ~syncC[2];
  wire [1:0] chipPins  = syncB[1:0];

  // ********************************
  // master clock presence
  // ********************************
  // clock gone means a stalled dynamic core: writes must not land then
  reg  [7:0] mclkIdle;
  wire       mclkPresent = (mclkIdle < MCLK_TIMEOUT);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      mclkIdle <= 8'h00;
    else if (mclkEdge)
      mclkIdle <= 8'h00;
    else if (mclkPresent)
      mclkIdle <= mclkIdle + 8'h01;
  end

  // ********************************
  // 3-wire receiver
  // ********************************
  reg  [15:0] spiShift;
  reg  [4:0]  spiCount;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      spiShift <= 16'h0000;
      spiCount <= 5'h00;
    end else if (twoWireSel || syncB[6]) begin
      if (csnRise || twoWireSel)
        spiCount <= 5'h00;
    end else if (cclkRise) begin
      spiShift <= {spiShift[14:0], syncB[4]};
      if (spiCount != 5'h1f)
        spiCount <= spiCount + 5'h01;
    end
  end

  // an over-long frame is dropped whole rather than guessed at
  wire spiGo = !twoWireSel && csnRise && (spiCount == `DAC_SPI_BITS)
               && headerOk(spiShift[15:8], 1'b1, chipPins);

  // ********************************
  // two-wire receiver
  // ********************************
  reg  [7:0] i2cShift;
  reg  [7:0] i2cHeader;
  reg  [7:0] i2cData;
  reg  [3:0] i2cBit;
  reg  [1:0] i2cByte;
  reg        i2cBusy;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      i2cShift  <= 8'h00;
      i2cHeader <= 8'h00;
      i2cData   <= 8'h00;
      i2cBit    <= 4'h0;
      i2cByte   <= 2'h0;
      i2cBusy   <= 1'b0;
      sdaOut    <= 1'b0;
      sdaOeN    <= 1'b1;
    end else if (!twoWireSel || i2cStart || i2cStop) begin
      i2cBusy <= twoWireSel && i2cStart;
      i2cBit  <= 4'h0;
      sdaOeN  <= 1'b1;
      if (i2cStart)
        i2cByte <= 2'h0;
    end else if (i2cBusy && sclRise && i2cBit < 4'h8) begin
      i2cShift <= {i2cShift[6:0], syncB[2]};
      i2cBit   <= i2cBit + 4'h1;
    end else if (i2cBusy && sclFall && i2cBit == 4'h8) begin
      i2cBit <= 4'h9;
      if (i2cByte == 2'h0 && headerOk(i2cShift, 1'b0, chipPins)) begin
        i2cHeader <= i2cShift;
        sdaOeN    <= 1'b0;
      end else if (i2cByte == 2'h1) begin
        i2cData <= i2cShift;
        sdaOeN  <= 1'b0;
      end else begin
        i2cBusy <= 1'b0;
      end
    end else if (i2cBusy && sclFall && i2cBit == 4'h9) begin
      sdaOeN  <= 1'b1;
      i2cBit  <= 4'h0;
      i2cByte <= i2cByte + 2'h1;
    end
  end

  wire       i2cGo  = twoWireSel && i2cStop && (i2cByte == 2'h2);
  wire       anyGo  = spiGo || i2cGo;
  wire [2:0] wrIdx  = spiGo ? spiShift[10:8] : i2cHeader[2:0];
  wire [7:0] wrData = spiGo ? spiShift[7:0] : i2cData;
  wire       wrEn   = anyGo && pdnOk && mclkPresent;

  // ********************************
  // register bank
  // ********************************
  reg  [7:0] regFile [0:`DAC_REG_COUNT-1];
  integer    i;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < `DAC_REG_COUNT; i = i + 1)
        regFile[i] <= defaultOf(i[2:0]);
    end else if (!pdnOk) begin
      for (i = 0; i < `DAC_REG_COUNT; i = i + 1)
        regFile[i] <= defaultOf(i[2:0]);
    end else if (wrEn) begin
      regFile[wrIdx] <= wrData;
      if (wrIdx == `DAC_REG_FORMAT)
        regFile[`DAC_REG_RATE][`DAC_TRST_BIT] <= wrData[`DAC_TRST_BIT];
      if (wrIdx == `DAC_REG_RATE)
        regFile[`DAC_REG_FORMAT][`DAC_TRST_BIT] <= wrData[`DAC_TRST_BIT];
    end
  end

  wire       trstBit  = regFile[`DAC_REG_FORMAT][`DAC_TRST_BIT];
  wire       softMute = regFile[`DAC_REG_MIX][`DAC_SOFT_MUTE_BIT_BIT];
  wire [1:0] speed    = regFile[`DAC_REG_RATE][`DAC_SPEED_HI:`DAC_SPEED_LO];

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      regFormat     <= `DAC_DEF_FORMAT;
      regRate       <= `DAC_DEF_RATE;
      regMix        <= `DAC_DEF_MIX;
      regLeftAtt    <= `DAC_DEF_LEFT_ATT;
      regRightAtt   <= `DAC_DEF_RIGHT_ATT;
      regDigitalOut <= `DAC_DEF_DOUT;
      regCsLow      <= `DAC_DEF_CS_LOW;
      regCsCategory <= `DAC_DEF_CS_CAT;
      deemphSelect  <= `DAC_DEEMPH_OFF;
    end else begin
      regFormat     <= regFile[`DAC_REG_FORMAT];
      regRate       <= regFile[`DAC_REG_RATE];
      regMix        <= regFile[`DAC_REG_MIX];
      regLeftAtt    <= regFile[`DAC_REG_LEFT_ATT];
      regRightAtt   <= regFile[`DAC_REG_RIGHT_ATT];
      regDigitalOut <= regFile[`DAC_REG_DOUT];
      regCsLow      <= regFile[`DAC_REG_CS_LOW];
      regCsCategory <= regFile[`DAC_REG_CS_CAT];
      if (speed != `DAC_SPEED_NORMAL)
        deemphSelect <= `DAC_DEEMPH_OFF;
      else
        deemphSelect <= regFile[`DAC_REG_MIX][`DAC_DEEMPH_HI:`DAC_DEEMPH_LO];
    end
  end

  // ********************************
  // timing reset sequencing
  // ********************************
  // frame counts only advance on frame edges, so a stopped clock just waits
  reg  [2:0] relCount;
  reg        zeroHold;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      relCount           <= 3'h0;
      zeroHold           <= 1'b0;
      internalReset      <= 1'b1;
      converterPowerDown <= 1'b1;
    end else begin
      converterPowerDown <= !pdnOk || internalReset;
      if (!pdnOk) begin
        relCount      <= 3'h0;
        zeroHold      <= 1'b0;
        internalReset <= 1'b1;
      end else if (!trstBit) begin
        relCount      <= 3'h0;
        zeroHold      <= 1'b1;
        internalReset <= 1'b1;
      end else if (fsTick && relCount != `DAC_ZHOLD_FRAMES) begin
        relCount <= relCount + 3'h1;
        if (relCount + 3'h1 == `DAC_RELEASE_FRAMES)
          internalReset <= 1'b0;
        if (relCount + 3'h1 == `DAC_ZHOLD_FRAMES)
          zeroHold <= 1'b0;
      end
    end
  end

  // ********************************
  // zero detection
  // ********************************
  reg  [13:0] zeroCount;
  wire        nonZero = sampleValid && ((sampleLeft != 24'h000000)
                                        || (sampleRight != 24'h000000));

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      zeroCount   <= 14'h0000;
      zeroFlagOut <= 1'b0;
    end else if (!pdnOk) begin
      zeroCount   <= 14'h0000;
      zeroFlagOut <= 1'b0;
    end else if (zeroHold || !trstBit) begin
      zeroCount   <= 14'h0000;
      zeroFlagOut <= 1'b1;
    end else if (nonZero) begin
      zeroCount   <= 14'h0000;
      zeroFlagOut <= 1'b0;
    end else if (fsTick && zeroCount != ZERO_FRAMES) begin
      zeroCount <= zeroCount + 14'h0001;
      if (zeroCount + 14'h0001 == ZERO_FRAMES)
        zeroFlagOut <= 1'b1;
    end else if (zeroCount != ZERO_FRAMES) begin
      zeroFlagOut <= 1'b0;
    end
  end

  // ********************************
  // soft mute ramp
  // ********************************
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      muteGain <= RAMP_STEPS;
    else if (!pdnOk || internalReset)
      muteGain <= RAMP_STEPS;
    else if (fsTick) begin
      if (softMute && muteGain != 11'h000)
        muteGain <= muteGain - 11'h001;
      else if (!softMute && muteGain != RAMP_STEPS)
        muteGain <= muteGain + 11'h001;
    end
  end

endmodule // dac_control_port

// [tb/host_ctl_model.sv]
// host model driving the 3-wire and two-wire control pins
`timescale 1ns/1ns
module host_ctl_model (
  input  wire clock,
  input  wire sdaLine,
  output reg  selectN,
  output reg  ctlSerialClock,
  output reg  ctlSerialIn,
  output reg  sclIn,
  output reg  sdaHost
);
  // select and both clocks rest high between accesses
  initial begin
    selectN = 1'b1;
    ctlSerialClock = 1'b1;
    ctlSerialIn = 1'b0;
    sclIn = 1'b1;
    sdaHost = 1'b1;
  end
  task tick(input integer n);
    repeat (n) @(posedge clock);
  endtask
  // callers only ever pass addresses 00h to 07h
  task write3(input [15:0] word);
    selectN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      tick(1);
      ctlSerialClock <= 1'b0;
      ctlSerialIn <= word[i];
      tick(4);
      ctlSerialClock <= 1'b1;
      tick(3);
    end
    tick(4);
    selectN <= 1'b1;
    // data line unselected: no stale level left behind
    ctlSerialIn <= ~word[0];
  endtask
  // sda only moves while scl is low, one clock after its fall
  task sendByte(input [7:0] b, output ack);
    for (int i = 7; i >= 0; i--) begin
      tick(1);
      sdaHost <= b[i];
      tick(3);
      sclIn <= 1'b1;
      tick(4);
      sclIn <= 1'b0;
    end
    tick(1);
    sdaHost <= 1'b1;
    tick(3);
    sclIn <= 1'b1;
    tick(2);
    ack = ~sdaLine;
    tick(2);
    sclIn <= 1'b0;
  endtask
  task write2(input [7:0] hdr, input [7:0] d, output ok);
    reg a1;
    reg a2;
    sdaHost <= 1'b0;
    tick(4);
    sclIn <= 1'b0;
    sendByte(hdr, a1);
    sendByte(d, a2);
    tick(1);
    sdaHost <= 1'b0;
    tick(3);
    sclIn <= 1'b1;
    tick(4);
    sdaHost <= 1'b1;
    ok = a1 & a2;
  endtask
endmodule // host_ctl_model

// [tb/dac_control_port_sva.sv]
// concurrent checks on the control port outputs
`timescale 1ns/1ns
module dac_control_port_sva #(
  parameter [10:0] RAMP_STEPS = 11'd1024
) (
  input wire        clock,
  input wire        arst_n,
  input wire        powerDownN,
  input wire        twoWireSel,
  input wire        sampleValid,
  input wire [23:0] sampleLeft,
  input wire [23:0] sampleRight,
  input wire        sdaOeN,
  input wire        zeroFlagOut,
  input wire [1:0]  deemphSelect,
  input wire [10:0] muteGain,
  input wire        converterPowerDown,
  input wire        internalReset,
  input wire [7:0]  regFormat,
  input wire [7:0]  regRate,
  input wire [7:0]  regMix
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_deemph_map: assert property (
    ($stable(regMix) && $stable(regRate) && regRate[5:4] == 2'h0)[*2]
    |-> deemphSelect == regMix[3:2]) else $error("deemph select wrong");
  a_deemph_forced: assert property (
    (regRate[5:4] != 2'h0)[*2] |-> deemphSelect == 2'h1) else $error("deemph not off");
  a_pd_flag_low: assert property (
    (!powerDownN)[*4] |-> !zeroFlagOut) else $error("zero flag high in power-down");
  a_pd_defaults: assert property (
    (!powerDownN)[*5] |-> regMix == 8'h94 && regFormat == 8'h0b && regRate == 8'h01)
    else $error("registers not at defaults");
  a_pd_conv_off: assert property (
    (!powerDownN)[*4] |-> internalReset && converterPowerDown) else $error("converter on");
  a_trst_shared: assert property (
    regFormat[0] == regRate[0]) else $error("timing reset copies differ");
  a_trst_state: assert property (
    (powerDownN && !regFormat[0])[*2] |-> zeroFlagOut && internalReset && converterPowerDown)
    else $error("timing reset state wrong");
  a_zero_drop: assert property (
    sampleValid && (sampleLeft != 24'h0 || sampleRight != 24'h0) && regFormat[0]
    && $past(regFormat[0]) |=> !zeroFlagOut) else $error("zero flag kept");
  a_gain_step: assert property (
    !internalReset && !$past(internalReset) && muteGain != $past(muteGain)
    |-> muteGain == $past(muteGain) + 11'h1 || muteGain + 11'h1 == $past(muteGain))
    else $error("gain jumped");
  a_gain_top: assert property (
    muteGain <= RAMP_STEPS) else $error("gain above full scale");
  a_ack_mode: assert property (
    !sdaOeN |-> twoWireSel) else $error("sda driven in 3-wire mode");
  cover property (!sdaOeN);
  cover property (zeroFlagOut && regFormat[0] && powerDownN);
  cover property (muteGain == 11'h0);
endmodule // dac_control_port_sva
bind dac_control_port dac_control_port_sva #(.RAMP_STEPS(RAMP_STEPS)) checker_i (
  .clock, .arst_n, .powerDownN, .twoWireSel, .sampleValid, .sampleLeft, .sampleRight,
  .sdaOeN, .zeroFlagOut, .deemphSelect, .muteGain, .converterPowerDown, .internalReset,
  .regFormat, .regRate, .regMix);

// [tb/test_dac_control_port.sv]
// self-checking bench for the control port and housekeeping
`timescale 1ns/1ns
module test_dac_control_port;
  localparam [10:0] RAMP = 11'd32;
  localparam [1:0]  CHIP = 2'h2;
  localparam [63:0] DEFAULTS = 64'h0b0194ffff010004;
  reg         clock, arst_n, powerDownN, twoWireSel, masterClockIn, frameClock, mclkOn;
  reg         sampleValid, ack;
  reg  [23:0] sampleLeft, sampleRight;
  reg  [10:0] g;
  wire        selectN, ctlSerialClock, ctlSerialIn, sclIn, sdaHost, sdaLine, sdaOut, sdaOeN;
  wire        zeroFlagOut, converterPowerDown, internalReset;
  wire [1:0]  deemphSelect;
  wire [10:0] muteGain;
  wire [7:0]  regFormat, regRate, regMix, regLeftAtt, regRightAtt, regDigitalOut, regCsLow;
  wire [7:0]  regCsCategory;
  wire [63:0] regsAll = {regFormat, regRate, regMix, regLeftAtt, regRightAtt, regDigitalOut,
                         regCsLow, regCsCategory};
  integer     err_count = 0, checks_done = 0, frames = 0, i, n0;
  // open drain with pull-up
  assign sdaLine = sdaHost & (sdaOeN | sdaOut);
  initial begin clock = 0; forever #5 clock = ~clock; end
  initial begin frameClock = 0; forever begin #63 frameClock = 1; #62 frameClock = 0; end end
  always @(posedge frameClock) frames <= frames + 1;
  always @(posedge clock) masterClockIn <= mclkOn & ~masterClockIn;
  dac_control_port #(.ZERO_FRAMES(14'd16), .RAMP_STEPS(RAMP)) dut (
    .clock, .arst_n, .powerDownN, .twoWireSel, .masterClockIn, .frameClock, .selectN,
    .ctlSerialClock, .ctlSerialIn, .sclIn, .sdaIn(sdaLine), .addrSelectPin0(1'b0),
    .addrSelectPin1(1'b1), .sampleValid, .sampleLeft, .sampleRight, .sdaOut, .sdaOeN,
    .zeroFlagOut, .deemphSelect, .muteGain, .converterPowerDown, .internalReset, .regFormat,
    .regRate, .regMix, .regLeftAtt, .regRightAtt, .regDigitalOut, .regCsLow, .regCsCategory);
  host_ctl_model host (.clock, .sdaLine, .selectN, .ctlSerialClock, .ctlSerialIn, .sclIn,
    .sdaHost);
  task chk(input string w, input [63:0] exp, input [63:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", w, exp, got);
    end
  endtask
  task wr(input [1:0] c, input rw, input [4:0] a, input [7:0] d);
    @(posedge clock);
    if (twoWireSel) host.write2({c, rw, a}, d, ack);
    else host.write3({c, rw, a, d});
    repeat (6) @(posedge clock);
  endtask
  task frameWait(input integer n);
    integer s;
    s = frames;
    while (frames < s + n) @(posedge clock);
  endtask
  task sample(input [23:0] l, input [23:0] r);
    sampleLeft <= l;
    sampleRight <= r;
    sampleValid <= 1'b1;
    @(posedge clock);
    sampleValid <= 1'b0;
    @(posedge clock);
  endtask
  task results;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // about 5000 clocks of traffic expected; generous margin
  initial begin #600000; err_count++; results; end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    arst_n = 0; powerDownN = 1; twoWireSel = 0; mclkOn = 1; masterClockIn = 0;
    sampleValid = 0; sampleLeft = 0; sampleRight = 0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk("defaults", DEFAULTS, regsAll);
    for (i = 0; i < 4; i++) begin
      wr(CHIP, 1'b1, 5'h02, {4'h9, i[1:0], 2'h0});
      chk("deemph", i, deemphSelect);
    end
    for (i = 1; i < 4; i++) begin
      wr(CHIP, 1'b1, 5'h01, {2'h0, i[1:0], 4'h1});
      chk("deemph forced", 1, deemphSelect);
    end
    wr(CHIP, 1'b1, 5'h01, 8'h01);
    wr(2'h1, 1'b1, 5'h05, 8'h02);
    wr(CHIP, 1'b0, 5'h05, 8'h02);
    chk("refused", 8'h01, regDigitalOut);
    twoWireSel <= 1'b1;
    wr(CHIP, 1'b0, 5'h06, 8'h5a);
    chk("ack", 1, ack);
    chk("two-wire write", 16'h5a04, {regCsLow, regCsCategory});
    wr(2'h0, 1'b0, 5'h06, 8'ha5);
    chk("two-wire refused", 9'h05a, {ack, regCsLow});
    twoWireSel <= 1'b0;
    wr(CHIP, 1'b1, 5'h00, 8'h0a);
    chk("timing reset", 4'he, {zeroFlagOut, internalReset, converterPowerDown, regRate[0]});
    chk("kept", 8'h9c, regMix);
    @(posedge clock);
    host.write3({CHIP, 1'b1, 5'h01, 8'h01});
    n0 = 0;
    // clock counts: frame is 12.5 clocks, plus sync and commit latency
    for (i = 0; i < 200 && zeroFlagOut !== 1'b0; i++) begin
      @(posedge clock);
      if (internalReset === 1'b1) n0 = i;
    end
    chk("release", 1, n0 >= 24 && n0 <= 46);
    chk("flag drop", 1, i >= 50 && i <= 72);
    sample(24'h1, 24'h0);
    frameWait(14);
    chk("zero early", 0, zeroFlagOut);
    frameWait(4);
    chk("zero flag", 1, zeroFlagOut);
    sample(24'h0, 24'h800000);
    chk("zero clear", 0, zeroFlagOut);
    sampleRight <= 24'h0;
    wr(CHIP, 1'b1, 5'h02, 8'h95);
    chk("ramp start", 1, muteGain >= RAMP - 11'd2);
    frameWait(RAMP + 2);
    chk("muted", 0, muteGain);
    wr(CHIP, 1'b1, 5'h02, 8'h94);
    frameWait(RAMP + 2);
    chk("unmuted", RAMP, muteGain);
    wr(CHIP, 1'b1, 5'h02, 8'h95);
    wr(CHIP, 1'b1, 5'h02, 8'h94);
    g = muteGain;
    frameWait(3);
    chk("mid-ramp rise", 1, muteGain > g && g != 11'h0);
    mclkOn <= 1'b0;
    repeat (100) @(posedge clock);
    wr(CHIP, 1'b1, 5'h03, 8'h12);
    chk("no master clock", 8'hff, regLeftAtt);
    mclkOn <= 1'b1;
    repeat (10) @(posedge clock);
    wr(CHIP, 1'b1, 5'h03, 8'h12);
    chk("left att", 8'h12, regLeftAtt);
    powerDownN <= 1'b0;
    repeat (8) @(posedge clock);
    chk("power-down regs", DEFAULTS, regsAll);
    chk("power-down flag", 0, zeroFlagOut);
    chk("sda out", 0, sdaOut);
    wr(CHIP, 1'b1, 5'h04, 8'h00);
    chk("power-down write", 8'hff, regRightAtt);
    powerDownN <= 1'b1;
    repeat (8) @(posedge clock);
    wr(CHIP, 1'b1, 5'h04, 8'h00);
    chk("right att", 8'h00, regRightAtt);
    results;
  end
endmodule // test_dac_control_port
